// *** pic_pkg.sv ***
// Constants, offsets and types shared by the priority interrupt controller.
package pic_pkg;

  // ==========================================================================
  // Source counts
  localparam int NUM_SRC = 60;
  localparam int NUM_CPU = 9;
  localparam int NUM_INT = 42;
  localparam int NUM_EXT = 9;
  localparam int NUM_PIN = 8;
  localparam int NUM_DMA = 8;
  localparam int NUM_PER = 33;
  localparam int NUM_MSK = NUM_PIN + NUM_PER + NUM_DMA;

  // ==========================================================================
  // Status register and levels
  localparam int MASK_LSB = 12;
  localparam int MASK_MSB = 14;
  localparam logic [2:0] LVL_NONE = 3'h0;
  localparam logic [2:0] LVL_MIN = 3'h1;
  localparam logic [2:0] LVL_TOP = 3'h7;
  localparam logic [2:0] MASK_RST = 3'h7;
  localparam logic [2:0] PRIO_RST = 3'h0;
  localparam logic [7:0] NEST_RST = 8'h00;
  localparam logic [23:0] SP_RST = 24'h000000;
  localparam logic [23:0] SP_STEP = 24'h000004;

  // ==========================================================================
  // Vector table
  localparam logic [23:0] VEC_TBL_BASE = 24'hFFFF00;
  localparam logic [23:0] VEC_TBL_END = 24'hFFFFEF;
  localparam int VEC_TBL_BYTES = 240;
  localparam logic [7:0] VEC_ILLEGAL = 8'h08;
  localparam logic [7:0] VEC_NMI = 8'h20;
  localparam logic [7:0] VEC_WDT = 8'h24;
  localparam logic [7:0] VEC_MSK0 = 8'h28;

  // ==========================================================================
  // Register port offsets
  localparam logic [7:0] ADDR_PRIO0 = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h40;
  localparam logic [7:0] ADDR_PEND = 8'h41;
  localparam logic [7:0] ADDR_DMA = 8'h42;

  // ==========================================================================
  // Micro DMA unit sizes
  localparam logic [1:0] DMA_SZ1 = 2'h0;
  localparam logic [1:0] DMA_SZ2 = 2'h1;
  localparam logic [1:0] DMA_SZ4 = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH_PC = 3'b001,
    ST_PUSH_SR = 3'b010,
    ST_JUMP = 3'b011,
    ST_FIRST = 3'b100
  } pic_state_t;

endpackage

// *** pic_core.sv ***
// Priority interrupt controller with processor acceptance sequencing.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/10ps
// Notes on behaviour
// - Mask lives in status bits 12..14 and gates acceptance.
// - Sixty sources: nine processor, forty-two internal, nine external pins.
// - Maskable sources get software priority; non-maskable sources are level 7.
// - Only the highest pending level is presented to the processor.
// - A request is accepted when its level is at least the mask.
// - Software and illegal-instruction traps ignore the mask.
// - Set-mask instruction loads its operand, effective next instruction.
// - Set-mask operand zero or absent behaves as operand one.
// - Mask-all instruction loads seven into the mask.
// - Micro DMA moves one, two or four byte units.
// - Software may start a micro DMA transfer directly.
// - Accept: read vector, push PC and SR, set mask, nest up, jump.
// - Traps skip vector read and mask update.
// - Equal levels resolve to smallest vector; read clears that request.
// - New mask is accepted level plus one, but seven stays seven.
// - Return pops PC and SR and decrements nesting count.
// - Maskable priority zero or seven never gives acceptance.
// - Higher level preempts; another non-maskable source preempts non-maskable.
// - Requests during acceptance wait until the handler's first instruction.
// - Reset loads mask with 111.
// - Vector table spans FFFF00 to FFFFEF.
module pic_core
  import pic_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Request sources
  input wire logic nmi_pin,
  input wire logic [NUM_PIN-1:0] external_request_pins,
  input wire logic wdt_req,
  input wire logic [NUM_PER-1:0] periph_req,
  input wire logic [NUM_DMA-1:0] dma_done,
  // Processor core events
  input wire logic instr_done,
  input wire logic trap_req,
  input wire logic [2:0] trap_num,
  input wire logic illegal_req,
  input wire logic set_mask_instruction,
  input wire logic [2:0] set_mask_operand,
  input wire logic mask_all_instruction,
  input wire logic return_from_handler,
  input wire logic [15:0] popped_sr,
  input wire logic [31:0] cpu_pc,
  input wire logic [11:0] cpu_flags,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Acceptance outputs to the core
  output logic [2:0] level_to_cpu,
  output logic [2:0] cpu_interrupt_mask,
  output logic [7:0] nesting_count,
  output logic [23:0] stack_pointer,
  output logic accept_busy,
  output logic push_valid,
  output logic [31:0] push_data,
  output logic jump_valid,
  output logic [23:0] jump_addr,
  output logic [7:0] vector,
  // Micro DMA start
  output logic dma_start,
  output logic [2:0] dma_chan,
  output logic [1:0] dma_size
);

  // ==========================================================================
  // Vector of a maskable source by its index.
  function automatic logic [7:0] msk_vector(input logic [5:0] idx);
    msk_vector = VEC_MSK0 + {idx, 2'b00};
  endfunction

  // A programmed level is usable only between one and six.
  function automatic logic lvl_usable(input logic [2:0] lvl);
    lvl_usable = (lvl != LVL_NONE) && (lvl != LVL_TOP);
  endfunction

  pic_state_t state_reg;
  logic [2:0] prio_reg [NUM_MSK];
  logic [NUM_MSK-1:0] pend_reg;
  logic nmi_pend_reg;
  logic wdt_pend_reg;
  logic [1:0] nmi_sync_reg;
  logic nmi_last_reg;
  logic [NUM_PIN-1:0] pin_s1_reg;
  logic [NUM_PIN-1:0] pin_s2_reg;
  logic [NUM_PIN-1:0] pin_last_reg;
  logic [2:0] acc_lvl_reg;
  logic acc_trap_reg;
  logic [7:0] acc_vec_reg;

  // ==========================================================================
  // Pin synchronisers; edges are taken from the second stage only.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      nmi_sync_reg <= 2'h0;
      nmi_last_reg <= 1'b0;
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_last_reg <= '0;
    end else begin
      nmi_sync_reg <= {nmi_sync_reg[0], nmi_pin};
      nmi_last_reg <= nmi_sync_reg[1];
      pin_s1_reg <= external_request_pins;
      pin_s2_reg <= pin_s1_reg;
      pin_last_reg <= pin_s2_reg;
    end
  end

  logic nmi_rise;
  logic [NUM_MSK-1:0] msk_set;
  assign nmi_rise = nmi_sync_reg[1] & ~nmi_last_reg;
  assign msk_set = {dma_done, periph_req, pin_s2_reg & ~pin_last_reg};

  // ==========================================================================
  // Priority resolution.
  logic [2:0] best_lvl;
  logic [5:0] best_idx;
  logic [2:0] sel_lvl;
  logic [7:0] sel_vec;
  logic [1:0] sel_kind;

  always_comb begin
    best_lvl = LVL_NONE;
    best_idx = 6'h00;
    // Scanning downward with >= lets the smaller vector win a tie.
    for (int i = NUM_MSK - 1; i >= 0; i--) begin
      if (pend_reg[i] && lvl_usable(prio_reg[i]) && prio_reg[i] >= best_lvl) begin
        best_lvl = prio_reg[i];
        best_idx = 6'(i);
      end
    end
    sel_lvl = best_lvl;
    sel_vec = msk_vector(best_idx);
    sel_kind = 2'h0;
    if (wdt_pend_reg) begin
      sel_lvl = LVL_TOP;
      sel_vec = VEC_WDT;
      sel_kind = 2'h2;
    end
    if (nmi_pend_reg) begin
      sel_lvl = LVL_TOP;
      sel_vec = VEC_NMI;
      sel_kind = 2'h3;
    end
  end

  // ==========================================================================
  // Acceptance decision at an instruction boundary.
  logic trap_go;
  logic int_go;
  assign trap_go = (state_reg == ST_IDLE) && (trap_req || illegal_req);
  assign int_go = (state_reg == ST_IDLE) && instr_done && !trap_go &&
                  (sel_lvl != LVL_NONE) && (level_to_cpu == sel_lvl) &&
                  (sel_lvl >= cpu_interrupt_mask);

  // Pending flags: a new request wins over the clear done by a vector read.
  logic [NUM_MSK-1:0] msk_clr;
  always_comb begin
    msk_clr = '0;
    if (int_go && sel_kind == 2'h0) begin
      msk_clr[best_idx] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_reg <= '0;
      nmi_pend_reg <= 1'b0;
      wdt_pend_reg <= 1'b0;
    end else begin
      pend_reg <= (pend_reg & ~msk_clr) | msk_set;
      nmi_pend_reg <= (nmi_pend_reg & ~(int_go && sel_kind == 2'h3)) | nmi_rise;
      wdt_pend_reg <= (wdt_pend_reg & ~(int_go && sel_kind == 2'h2)) | wdt_req;
    end
  end

  // ==========================================================================
  // Acceptance sequence.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      acc_lvl_reg <= LVL_NONE;
      acc_trap_reg <= 1'b0;
      acc_vec_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (trap_go) begin
            acc_trap_reg <= 1'b1;
            acc_lvl_reg <= LVL_NONE;
            acc_vec_reg <= illegal_req ? VEC_ILLEGAL : {3'h0, trap_num, 2'h0};
            state_reg <= ST_PUSH_PC;
          end else if (int_go) begin
            acc_trap_reg <= 1'b0;
            acc_lvl_reg <= sel_lvl;
            acc_vec_reg <= sel_vec;
            state_reg <= ST_PUSH_PC;
          end
        end
        ST_PUSH_PC: begin
          state_reg <= ST_PUSH_SR;
        end
        ST_PUSH_SR: begin
          state_reg <= ST_JUMP;
        end
        ST_JUMP: begin
          state_reg <= ST_FIRST;
        end
        ST_FIRST: begin
          if (instr_done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Mask field. The sequence outranks instructions since none retire in it.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpu_interrupt_mask <= MASK_RST;
    end else if (state_reg == ST_PUSH_SR && !acc_trap_reg) begin
      cpu_interrupt_mask <= (acc_lvl_reg == LVL_TOP) ? LVL_TOP : acc_lvl_reg + 3'h1;
    end else if (return_from_handler) begin
      cpu_interrupt_mask <= popped_sr[MASK_MSB:MASK_LSB];
    end else if (mask_all_instruction) begin
      cpu_interrupt_mask <= LVL_TOP;
    end else if (set_mask_instruction) begin
      cpu_interrupt_mask <= (set_mask_operand == LVL_NONE) ? LVL_MIN : set_mask_operand;
    end
  end

  // ==========================================================================
  // Stacking, nesting and jump outputs.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stack_pointer <= SP_RST;
      push_valid <= 1'b0;
      push_data <= 32'h00000000;
    end else if (state_reg == ST_PUSH_PC) begin
      stack_pointer <= stack_pointer - SP_STEP;
      push_valid <= 1'b1;
      push_data <= cpu_pc;
    end else if (state_reg == ST_PUSH_SR) begin
      stack_pointer <= stack_pointer - SP_STEP;
      push_valid <= 1'b1;
      push_data <= {16'h0000, 1'b0, cpu_interrupt_mask, cpu_flags};
    end else begin
      push_valid <= 1'b0;
      if (return_from_handler) begin
        stack_pointer <= stack_pointer + SP_STEP + SP_STEP;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      nesting_count <= NEST_RST;
    end else if (state_reg == ST_JUMP) begin
      nesting_count <= nesting_count + 8'h01;
    end else if (return_from_handler) begin
      nesting_count <= nesting_count - 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      jump_valid <= 1'b0;
      jump_addr <= VEC_TBL_BASE;
      vector <= 8'h00;
    end else begin
      jump_valid <= (state_reg == ST_JUMP);
      if (state_reg == ST_JUMP) begin
        jump_addr <= VEC_TBL_BASE + {16'h0000, acc_vec_reg};
        vector <= acc_vec_reg;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      level_to_cpu <= LVL_NONE;
      accept_busy <= 1'b0;
    end else begin
      level_to_cpu <= sel_lvl;
      accept_busy <= trap_go || int_go || (state_reg != ST_IDLE &&
                     !(state_reg == ST_FIRST && instr_done));
    end
  end

  // ==========================================================================
  // Register port: priorities, status, pending view and DMA software start.
  logic prio_hit;
  logic [5:0] prio_idx;
  assign prio_idx = reg_addr[5:0];
  assign prio_hit = (reg_addr[7:6] == ADDR_PRIO0[7:6]) && (prio_idx < 6'(NUM_MSK));

  generate
    for (genvar g = 0; g < NUM_MSK; g++) begin : g_prio
      always_ff @(posedge core_clk) begin
        if (rst) begin
          prio_reg[g] <= PRIO_RST;
        end else if (reg_wr && prio_hit && prio_idx == 6'(g)) begin
          prio_reg[g] <= reg_wdata[2:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (prio_hit) begin
        reg_rdata <= {13'h0000, prio_reg[prio_idx]};
      end else if (reg_addr == ADDR_STAT) begin
        reg_rdata <= {nesting_count, 1'b0, cpu_interrupt_mask, 4'h0};
      end else if (reg_addr == ADDR_PEND) begin
        reg_rdata <= {5'h00, sel_lvl, sel_vec};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // A size code of three names no unit, so such a write starts nothing.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dma_start <= 1'b0;
      dma_chan <= 3'h0;
      dma_size <= DMA_SZ1;
    end else if (reg_wr && reg_addr == ADDR_DMA && reg_wdata[4:3] != 2'h3) begin
      dma_start <= 1'b1;
      dma_chan <= reg_wdata[2:0];
      dma_size <= reg_wdata[4:3];
    end else begin
      dma_start <= 1'b0;
    end
  end

endmodule // pic_core

// *** pic_core_properties.sv ***
// Port assertions for the priority interrupt controller.
`timescale 1ns/10ps
module pic_core_properties
  import pic_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Core events
  input wire logic instr_done,
  input wire logic trap_req,
  input wire logic illegal_req,
  input wire logic set_mask_instruction,
  input wire logic [2:0] set_mask_operand,
  input wire logic mask_all_instruction,
  input wire logic return_from_handler,
  // Acceptance outputs
  input wire logic [2:0] level_to_cpu,
  input wire logic [2:0] cpu_interrupt_mask,
  input wire logic [7:0] nesting_count,
  input wire logic [23:0] stack_pointer,
  input wire logic accept_busy,
  input wire logic jump_valid,
  input wire logic [23:0] jump_addr,
  input wire logic [7:0] vector
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ==========
  // Mask field
  AST_RST_MASK: assert property ($fell(rst) |-> cpu_interrupt_mask == MASK_RST)
    else $error("mask not set by reset");
  AST_SET_MASK: assert property (set_mask_instruction && !mask_all_instruction
    && !return_from_handler && !accept_busy
    |=> cpu_interrupt_mask == (set_mask_operand == 3'h0 ? LVL_MIN : set_mask_operand))
    else $error("set mask wrong");
  AST_MASK_ALL: assert property (mask_all_instruction && !return_from_handler
    && !accept_busy |=> cpu_interrupt_mask == LVL_TOP)
    else $error("mask all wrong");
  // ==========
  // Acceptance
  AST_ACCEPT_GATE: assert property ($rose(accept_busy) |-> $past(trap_req)
    || $past(illegal_req) || $past(instr_done) && $past(level_to_cpu) != 3'h0
    && $past(level_to_cpu) >= $past(cpu_interrupt_mask))
    else $error("acceptance without cause");
  AST_MASK_RAISE: assert property ($rose(accept_busy) && !$past(trap_req)
    && !$past(illegal_req) |-> ##3 cpu_interrupt_mask == ($past(level_to_cpu, 4) == LVL_TOP
    ? LVL_TOP : $past(level_to_cpu, 4) + 3'h1))
    else $error("mask after acceptance wrong");
  AST_STACKING: assert property ($rose(accept_busy) |-> ##5
    stack_pointer == $past(stack_pointer, 5) - 24'h000008
    && nesting_count == $past(nesting_count, 5) + 8'h01)
    else $error("stacking wrong");
  AST_JUMP_TABLE: assert property (jump_valid |-> jump_addr == VEC_TBL_BASE
    + {16'h0000, vector} && jump_addr <= VEC_TBL_END)
    else $error("jump address wrong");
  AST_BUSY_HOLD: assert property ($rose(accept_busy) |-> accept_busy [*4])
    else $error("busy dropped early");
  AST_RET_NEST: assert property (return_from_handler && !accept_busy
    |=> nesting_count == $past(nesting_count) - 8'h01)
    else $error("return nesting wrong");
endmodule // pic_core_properties

bind pic_core pic_core_properties chk_u (.core_clk, .rst, .instr_done, .trap_req, .illegal_req,
  .set_mask_instruction, .set_mask_operand, .mask_all_instruction, .return_from_handler,
  .level_to_cpu, .cpu_interrupt_mask, .nesting_count, .stack_pointer, .accept_busy,
  .jump_valid, .jump_addr, .vector);

// *** pic_core_model.sv ***
// Behavioural processor core that retires instructions and keeps stacked status words.
`timescale 1ns/10ps
module pic_core_model
  import pic_pkg::*;
#(
  parameter int GAP = 4
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bench control
  input wire logic run,
  // Controller side
  output logic instr_done,
  output logic [31:0] cpu_pc,
  output logic [11:0] cpu_flags,
  input wire logic push_valid,
  input wire logic [31:0] push_data,
  input wire logic return_from_handler,
  output logic [15:0] popped_sr
);
  logic [7:0] gap_reg;
  logic second_reg;
  logic [2:0] depth_reg;
  logic [15:0] sr_mem [8];
  // ==========
  // A stopped core retires nothing, so only a trap or illegal-instruction request can start an acceptance while stopped.
  always_ff @(posedge core_clk) begin
    if (rst || !run) begin
      gap_reg <= 8'h00;
      instr_done <= 1'b0;
    end else begin
      gap_reg <= (gap_reg == 8'(GAP - 1)) ? 8'h00 : gap_reg + 8'h01;
      instr_done <= (gap_reg == 8'h00);
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpu_pc <= 32'h00001000;
    end else if (instr_done) begin
      cpu_pc <= cpu_pc + 32'h00000002;
    end
  end
  assign cpu_flags = 12'h0A5;
  // ==========
  // The second word of each push pair is the status word.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      second_reg <= 1'b0;
      depth_reg <= 3'h0;
    end else if (push_valid) begin
      second_reg <= !second_reg;
      if (second_reg) begin
        sr_mem[depth_reg] <= push_data[15:0];
        depth_reg <= depth_reg + 3'h1;
      end
    end else if (return_from_handler && depth_reg != 3'h0) begin
      depth_reg <= depth_reg - 3'h1;
    end
  end
  assign popped_sr = (depth_reg == 3'h0) ? 16'h7000 : sr_mem[depth_reg - 3'h1];
endmodule // pic_core_model

// *** pic_core_tb.sv ***
// Self-checking bench for the priority interrupt controller.
`timescale 1ns/10ps
module pic_core_tb;
  import pic_pkg::*;
  localparam logic [4:0] E_SET = 5'h01;
  localparam logic [4:0] E_ALL = 5'h02;
  localparam logic [4:0] E_WDT = 5'h04;
  localparam logic [4:0] E_TRAP = 5'h08;
  localparam logic [4:0] E_RET = 5'h10;
  logic core_clk, rst, run, wdt_req, trap_req, illegal_req, instr_done, reg_wr, reg_rd;
  logic set_mask_instruction, mask_all_instruction, return_from_handler;
  logic accept_busy, push_valid, jump_valid, dma_start;
  logic [2:0] trap_num, set_mask_operand, level_to_cpu, cpu_interrupt_mask, dma_chan;
  logic [1:0] dma_size;
  logic [7:0] reg_addr, nesting_count, vector;
  logic [11:0] cpu_flags;
  logic [15:0] reg_wdata, reg_rdata, popped_sr;
  logic [23:0] stack_pointer, jump_addr;
  logic [31:0] cpu_pc, push_data;
  logic [32:0] periph_req;
  int error_cnt = 0;
  int comparisons = 0;

  pic_core dut_u (
    .core_clk, .rst, .nmi_pin(1'b0), .external_request_pins(8'h00), .wdt_req, .periph_req,
    .dma_done(8'h00), .instr_done, .trap_req, .trap_num, .illegal_req, .set_mask_instruction,
    .set_mask_operand, .mask_all_instruction, .return_from_handler, .popped_sr, .cpu_pc,
    .cpu_flags, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .level_to_cpu,
    .cpu_interrupt_mask, .nesting_count, .stack_pointer, .accept_busy, .push_valid, .push_data,
    .jump_valid, .jump_addr, .vector, .dma_start, .dma_chan, .dma_size
  );
  pic_core_model #(.GAP(4)) core_u (
    .core_clk, .rst, .run, .instr_done, .cpu_pc, .cpu_flags, .push_valid, .push_data,
    .return_from_handler, .popped_sr
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ==========
  // Bench tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("%0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge core_clk);
  endtask
  // One-cycle core event; op is the mask operand or trap number.
  task automatic ev(input logic [4:0] s, input logic [2:0] op);
    {return_from_handler, trap_req, wdt_req, mask_all_instruction, set_mask_instruction} <= s;
    set_mask_operand <= op;
    trap_num <= op;
    @(posedge core_clk);
    {return_from_handler, trap_req, wdt_req, mask_all_instruction, set_mask_instruction} <= 5'h00;
    @(posedge core_clk);
  endtask
  task automatic jump(input logic [23:0] a);
    int i;
    for (i = 0; i < 60 && jump_valid !== 1'b1; i++) begin
      @(posedge core_clk);
    end
    if (i == 60) begin
      error_cnt++;
      test_done();
    end
    chk(jump_addr, a);
    repeat (8) @(posedge core_clk);
  endtask
  // ==========
  // Scenarios
  initial begin
    {rst, run, wdt_req, trap_req, illegal_req, reg_wr, reg_rd} = 7'h40;
    {set_mask_instruction, mask_all_instruction, return_from_handler} = 3'h0;
    {trap_num, set_mask_operand, reg_addr, reg_wdata, periph_req} = '0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk(cpu_interrupt_mask, 3'h7);
    chk(nesting_count, 8'h00);
    chk(level_to_cpu, 3'h0);
    rd(ADDR_STAT, 16'h0070);
    rd(8'h50, 16'h0000);
    $display("test reset done");
    wr(8'h08, 16'h0004);
    wr(8'h09, 16'h0004);
    wr(8'h0A, 16'h0007);
    rd(8'h08, 16'h0004);
    periph_req <= 33'h7;
    @(posedge core_clk);
    periph_req <= '0;
    repeat (3) @(posedge core_clk);
    chk(level_to_cpu, 3'h4);
    rd(ADDR_PEND, 16'h0448);
    run <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk(accept_busy, 1'b0);
    run <= 1'b0;
    ev(E_SET, 3'h0);
    chk(cpu_interrupt_mask, 3'h1);
    run <= 1'b1;
    jump(24'hFFFF48);
    chk(stack_pointer, 24'hFFFFF8);
    chk(vector, 8'h48);
    chk(cpu_interrupt_mask, 3'h5);
    chk(level_to_cpu, 3'h4);
    ev(E_RET, 3'h0);
    jump(24'hFFFF4C);
    chk(nesting_count, 8'h01);
    ev(E_RET, 3'h0);
    repeat (6) @(posedge core_clk);
    chk(nesting_count, 8'h00);
    chk(level_to_cpu, 3'h0);
    $display("test maskable done");
    run <= 1'b0;
    ev(E_SET, 3'h5);
    chk(cpu_interrupt_mask, 3'h5);
    run <= 1'b1;
    ev(E_TRAP, 3'h3);
    jump(24'hFFFF0C);
    chk(cpu_interrupt_mask, 3'h5);
    ev(E_RET, 3'h0);
    ev(E_ALL, 3'h0);
    chk(cpu_interrupt_mask, 3'h7);
    ev(E_WDT, 3'h0);
    jump(24'hFFFF24);
    chk(cpu_interrupt_mask, 3'h7);
    ev(E_TRAP, 3'h3);
    jump(24'hFFFF0C);
    chk(nesting_count, 8'h02);
    ev(E_RET, 3'h0);
    ev(E_RET, 3'h0);
    chk(nesting_count, 8'h00);
    $display("test non-maskable done");
    for (int s = 0; s < 4; s++) begin
      reg_addr <= ADDR_DMA;
      reg_wdata <= 16'(s * 8 + 5);
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1 chk(dma_start, (s != 3));
      chk(dma_size, (s == 3) ? 2 : s);
      chk(dma_chan, 3'h5);
      @(posedge core_clk);
    end
    $display("test dma done");
    illegal_req <= 1'b1;
    @(posedge core_clk);
    illegal_req <= 1'b0;
    jump(24'hFFFF08);
    ev(E_RET, 3'h0);
    chk(nesting_count, 8'h00);
    $display("test illegal done");
    test_done();
  end
endmodule // pic_core_tb
